// *** design/sflash_cmd.sv ***
// serial flash command interpreter: latch, identity, status and array reads
`timescale 1ns/1ps
module sflash_cmd import sflash_pkg::*; #(
   parameter logic [7:0] MAKER_CODE = 8'h5a, // arbitrary value
   parameter logic [7:0] MEM_TYPE = 8'ha5, // arbitrary value
   parameter logic [7:0] MEM_CAPACITY = 8'h3c, // arbitrary value
   parameter int FIFO_DEPTH = 16
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire spi_in_t spi_in,
   output logic dout,
   output logic dout_oe_n,
   input wire logic engine_busy,
   input wire logic engine_done,
   output logic [ADDR_BITS-1:0] mem_addr,
   output logic mem_req,
   input wire logic mem_valid,
   input wire logic [7:0] mem_data,
   output logic write_latch_flag,
   output logic [7:0] flash_status_byte
);
   // two-flop synchronisers for pins
   spi_in_t sync1;
   spi_in_t sync2;
   logic sclk_prev;
   logic sel_prev_n;
   always_ff @(posedge clk) begin
      sync1 <= spi_in;
      sync2 <= sync1;
      sclk_prev <= sync2.sclk;
      sel_prev_n <= sync2.sel_n;
   end
   wire logic sel_n = sync2.sel_n;
   wire logic rise = !sel_n && sync2.sclk && !sclk_prev;
   wire logic fall = !sel_n && !sync2.sclk && sclk_prev;
   wire logic sel_rise = sync2.sel_n && !sel_prev_n;
   wire logic sel_fall = !sync2.sel_n && sel_prev_n;

   state_t state;
   source_t src;
   logic [2:0] bitcnt;
   logic [7:0] shin;
   logic [7:0] opcode;
   logic [4:0] byte_cnt;
   logic [1:0] addr_bytes;
   logic [ADDR_BITS-1:0] addr;
   logic [7:0] shout;
   logic frame_ok;
   logic busy_flag;
   logic [4:0] id_idx;
   logic out_started;
   logic fetch_pend;

   wire logic [7:0] next_shin = {shin[6:0], sync2.din};
   wire logic byte_done = rise && bitcnt == 3'd7;
   // last address bit: fetch starts here so the first byte is ready by the next fall
   wire logic addr_last = byte_done && state == ST_ADDR && addr_bytes == 2'd2;
   wire logic [ADDR_BITS-1:0] addr_in = {addr[ADDR_BITS-2:0], sync2.din};
   wire logic is_set = opcode == OP_SET_LATCH;
   wire logic is_clear = opcode == OP_CLEAR_LATCH;
   wire logic latch_frame = (is_set || is_clear) && frame_ok && bitcnt == 3'd0;
   wire logic next_busy = engine_busy;
   wire logic [7:0] status_val = {6'h00, write_latch_flag, busy_flag};
   logic [7:0] id_byte;
   always_comb begin
      case (id_idx)
         5'd0: id_byte = MAKER_CODE;
         5'd1: id_byte = MEM_TYPE;
         5'd2: id_byte = MEM_CAPACITY;
         5'd3: id_byte = UID_LENGTH;
         default: id_byte = CUSTOMER_DEFAULT;
      endcase
   end

   // array data path through the fifo; fetch stalls when fifo full
   logic f_in_ready;
   logic f_out_valid;
   logic [7:0] f_out_data;
   wire logic f_pop = fall && bitcnt == 3'd0 && state == ST_OUT && src == SRC_ARRAY;
   sflash_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(clk),
      .rst_n(rst_n),
      .flush(sel_n),
      .in_valid(mem_valid && !sel_n),
      .in_ready(f_in_ready),
      .in_data(mem_data),
      .out_valid(f_out_valid),
      .out_ready(f_pop),
      .out_data(f_out_data)
   );
   wire logic [7:0] arr_byte = f_out_valid ? f_out_data : 8'hff;

   always_ff @(posedge clk) begin
      if (!rst_n) busy_flag <= 1'b0;
      else busy_flag <= next_busy;
   end
   always_ff @(posedge clk) begin
      if (!rst_n) flash_status_byte <= 8'h00;
      else flash_status_byte <= status_val;
   end

   // latch update: completion of engine op wins over set or clear in the same cycle
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         write_latch_flag <= WRITE_LATCH_RESET;
      end else if (engine_done) begin
         write_latch_flag <= 1'b0;
      end else if (sel_rise && latch_frame) begin
         write_latch_flag <= is_set;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n || sel_n) begin
         state <= ST_OPCODE;
         bitcnt <= 3'd0;
         frame_ok <= 1'b1;
         opcode <= 8'h00;
         src <= SRC_STATUS;
         byte_cnt <= 5'd0;
         id_idx <= 5'd0;
         addr_bytes <= 2'd0;
         out_started <= 1'b0;
      end else if (rise) begin
         bitcnt <= bitcnt + 3'd1;
         shin <= next_shin;
         if (bitcnt == 3'd7) begin
            case (state)
               ST_OPCODE: begin
                  opcode <= next_shin;
                  frame_ok <= 1'b1;
                  case (next_shin)
                     OP_STATUS: begin
                        state <= ST_OUT;
                        src <= SRC_STATUS;
                     end
                     OP_IDENTITY: begin
                        state <= busy_flag ? ST_IGNORE : ST_OUT;
                        src <= SRC_IDENT;
                     end
                     OP_READ, OP_FAST_READ: begin
                        state <= busy_flag ? ST_IGNORE : ST_ADDR;
                        src <= SRC_ARRAY;
                     end
                     default: state <= ST_IGNORE;
                  endcase
               end
               ST_ADDR: begin
                  addr_bytes <= addr_bytes + 2'd1;
                  if (addr_bytes == 2'd2) begin
                     state <= opcode == OP_FAST_READ ? ST_DUMMY : ST_OUT;
                  end
               end
               ST_DUMMY: state <= ST_OUT;
               default: state <= state;
            endcase
            if (state != ST_OPCODE) frame_ok <= 1'b0;
         end else if (state == ST_OPCODE && opcode != 8'h00) begin
            frame_ok <= 1'b0;
         end
      end else if (f_pop || (fall && bitcnt == 3'd0 && state == ST_OUT)) begin
         out_started <= 1'b1;
         if (src == SRC_IDENT && id_idx != 5'(ID_BYTES)) id_idx <= id_idx + 5'd1;
      end
   end

   // address assembly and array fetch
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         addr <= ADDR_WRAP;
         fetch_pend <= 1'b0;
      end else if (rise && state == ST_ADDR) begin
         addr <= addr_in;
         fetch_pend <= 1'b0;
      end else if (mem_req) begin
         addr <= addr + 21'd1;
      end
   end
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         mem_req <= 1'b0;
         mem_addr <= ADDR_WRAP;
      end else begin
         mem_req <= addr_last || (!sel_n && src == SRC_ARRAY
            && (state == ST_OUT || state == ST_DUMMY) && f_in_ready && !mem_req && !mem_valid);
         mem_addr <= addr_last ? addr_in : addr;
      end
   end

   // output shifter: load on byte boundary falling edge, shift otherwise
   wire logic [7:0] load_byte = src == SRC_STATUS ? status_val :
      src == SRC_IDENT ? (id_idx == 5'(ID_BYTES) ? 8'h00 : id_byte) : arr_byte;
   always_ff @(posedge clk) begin
      if (!rst_n || sel_n) begin
         shout <= 8'h00;
         dout <= DOUT_RESET;
         dout_oe_n <= DOUT_OE_RESET_N;
      end else if (fall && state == ST_OUT) begin
         if (bitcnt == 3'd0) begin
            dout <= load_byte[7];
            shout <= {load_byte[6:0], 1'b0};
         end else begin
            dout <= shout[7];
            shout <= {shout[6:0], 1'b0};
         end
         dout_oe_n <= 1'b0;
      end
   end

   AST_STATUS_BITS: assert property (@(posedge clk) disable iff (!rst_n)
      flash_status_byte[7:2] == 6'h00) else $error("status high bits nonzero");
   AST_BUSY_FOLLOW: assert property (@(posedge clk) disable iff (!rst_n)
      ##1 busy_flag == $past(engine_busy)) else $error("busy flag lags");
   AST_DONE_CLEARS: assert property (@(posedge clk) disable iff (!rst_n)
      engine_done |=> !write_latch_flag) else $error("latch not cleared");
   AST_SEL_STOP: assert property (@(posedge clk) disable iff (!rst_n)
      sel_n |=> dout_oe_n) else $error("output driven after select");
   AST_ID_BUSY: assert property (@(posedge clk) disable iff (!rst_n)
      (byte_done && state == ST_OPCODE && next_shin == OP_IDENTITY && busy_flag)
      |=> state == ST_IGNORE) else $error("identity decoded while busy");
   AST_READ_BUSY: assert property (@(posedge clk) disable iff (!rst_n)
      (byte_done && state == ST_OPCODE && next_shin == OP_READ && busy_flag)
      |=> state == ST_IGNORE) else $error("read decoded while busy");
   AST_SET: assert property (@(posedge clk) disable iff (!rst_n)
      (sel_rise && latch_frame && is_set && !engine_done) |=> write_latch_flag)
      else $error("set latch failed");
   AST_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
      (sel_rise && latch_frame && is_clear) |=> !write_latch_flag)
      else $error("clear latch failed");
   AST_ODD_FRAME: assert property (@(posedge clk) disable iff (!rst_n)
      (sel_rise && bitcnt != 3'd0 && !engine_done) |=> $stable(write_latch_flag))
      else $error("partial frame changed latch");
   COV_SET: cover property (@(posedge clk) sel_rise && latch_frame && is_set);
   COV_STATUS: cover property (@(posedge clk) state == ST_OUT && src == SRC_STATUS);
   COV_IDENT: cover property (@(posedge clk) id_idx == 5'd4);
   COV_ARRAY: cover property (@(posedge clk) f_pop && f_out_valid);
endmodule

// *** design/sflash_fifo.sv ***
// small valid/ready fifo for array read data
`timescale 1ns/1ps
module sflash_fifo import sflash_pkg::*; #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic flush,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wp;
   logic [AW:0] rp;
   wire logic do_wr = in_valid && in_ready;
   wire logic do_rd = out_valid && out_ready;
   assign in_ready = (wp - rp) != (AW+1)'(DEPTH);
   assign out_valid = wp != rp;
   assign out_data = mem[rp[AW-1:0]];
   always_ff @(posedge clk) begin
      if (do_wr) begin
         mem[wp[AW-1:0]] <= in_data;
      end
   end
   always_ff @(posedge clk) begin
      if (!rst_n || flush) begin
         wp <= '0;
         rp <= '0;
      end else begin
         if (do_wr) wp <= wp + 1'b1;
         if (do_rd) rp <= rp + 1'b1;
      end
   end
endmodule

// *** design/sflash_pkg.sv ***
// shared constants and types for the serial flash command front end
package sflash_pkg;
   localparam logic [7:0] OP_SET_LATCH = 8'h06;
   localparam logic [7:0] OP_CLEAR_LATCH = 8'h04;
   localparam logic [7:0] OP_IDENTITY = 8'h9f;
   localparam logic [7:0] OP_STATUS = 8'h05;
   localparam logic [7:0] OP_READ = 8'h03;
   localparam logic [7:0] OP_FAST_READ = 8'h0b;
   localparam logic [7:0] UID_LENGTH = 8'h10;
   localparam logic [7:0] CUSTOMER_DEFAULT = 8'h00;
   localparam int ID_BYTES = 20;
   localparam int ADDR_BITS = 21;
   localparam int STAT_BUSY_POS = 0;
   localparam int STAT_LATCH_POS = 1;
   localparam logic [20:0] ADDR_WRAP = 21'h000000;
   localparam logic WRITE_LATCH_RESET = 1'b0;
   localparam logic DOUT_RESET = 1'b0;
   localparam logic DOUT_OE_RESET_N = 1'b1;
   typedef enum logic [2:0] {
      ST_OPCODE = 3'b000,
      ST_ADDR = 3'b001,
      ST_DUMMY = 3'b010,
      ST_OUT = 3'b011,
      ST_IGNORE = 3'b100
   } state_t;
   typedef enum logic [1:0] {
      SRC_STATUS = 2'b00,
      SRC_IDENT = 2'b01,
      SRC_ARRAY = 2'b10
   } source_t;
   typedef struct packed {
      logic sel_n;
      logic sclk;
      logic din;
   } spi_in_t;
endpackage

// *** dv/sflash_cmd_tb.sv ***
// self-checking bench for the flash command front end
`timescale 1ns/1ps
module sflash_cmd_tb import sflash_pkg::*;;
   localparam logic [7:0] MAKER = 8'h71; // arbitrary value
   localparam logic [7:0] MTYPE = 8'h2e; // arbitrary value
   localparam logic [7:0] MCAP = 8'hc3; // arbitrary value
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   spi_in_t spi_in;
   logic dout, dout_oe_n, mem_req, write_latch_flag;
   logic engine_busy = 1'b0;
   logic engine_done = 1'b0;
   logic mem_valid = 1'b0;
   logic [7:0] mem_data = 8'h00;
   logic [ADDR_BITS-1:0] mem_addr;
   logic [7:0] flash_status_byte, rx;
   int fail_count = 0;
   int compares = 0;
   sflash_cmd #(.MAKER_CODE(MAKER), .MEM_TYPE(MTYPE), .MEM_CAPACITY(MCAP)) u_sflash_cmd (
      .clk(clk), .rst_n(rst_n), .spi_in(spi_in), .dout(dout), .dout_oe_n(dout_oe_n),
      .engine_busy(engine_busy), .engine_done(engine_done), .mem_addr(mem_addr),
      .mem_req(mem_req), .mem_valid(mem_valid), .mem_data(mem_data),
      .write_latch_flag(write_latch_flag), .flash_status_byte(flash_status_byte));
   spi_host u_host (.clk(clk), .spi_in(spi_in), .dout(dout), .dout_oe_n(dout_oe_n));
   always #50 clk = ~clk;
   function automatic logic [7:0] pat(input logic [20:0] a);
      return a[7:0] ^ {a[20:16], 3'b000};
   endfunction
   // memory answers one clock after each fetch
   always @(posedge clk) begin
      mem_valid <= mem_req;
      mem_data <= pat(mem_addr);
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic test_done;
      $display("compares=%0d mismatches=%0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic cmd(input logic [7:0] op, input int n);
      u_host.frame_open;
      u_host.shift(op, n, rx);
      u_host.frame_close;
   endtask
   task automatic status_read(input logic [7:0] exp);
      u_host.frame_open;
      u_host.shift(OP_STATUS, 8, rx);
      repeat (2) begin
         u_host.shift(8'h00, 8, rx);
         check(rx, exp);
         check(flash_status_byte, exp);
      end
      u_host.frame_close;
      check({7'h0, dout_oe_n}, 8'h01);
   endtask
   task automatic t_latch;
      check({7'h0, write_latch_flag}, 8'h00);
      cmd(OP_SET_LATCH, 8);
      check({7'h0, write_latch_flag}, 8'h01);
      status_read(8'h02);
      cmd(OP_CLEAR_LATCH, 7);
      check({7'h0, write_latch_flag}, 8'h01);
      cmd(OP_CLEAR_LATCH, 8);
      check({7'h0, write_latch_flag}, 8'h00);
      cmd(OP_SET_LATCH, 12);
      check({7'h0, write_latch_flag}, 8'h00);
      cmd(OP_SET_LATCH, 8);
      engine_done <= 1'b1;
      @(posedge clk);
      engine_done <= 1'b0;
      repeat (3) @(posedge clk);
      check({7'h0, write_latch_flag}, 8'h00);
      $display("test latch done");
   endtask
   task automatic t_ident;
      logic [7:0] exp;
      u_host.frame_open;
      u_host.shift(OP_IDENTITY, 8, rx);
      for (int i = 0; i < 20; i++) begin
         exp = (i == 0) ? MAKER : (i == 1) ? MTYPE : (i == 2) ? MCAP :
            (i == 3) ? UID_LENGTH : CUSTOMER_DEFAULT;
         u_host.shift(8'h00, 8, rx);
         check(rx, exp);
      end
      u_host.shift(8'h00, 3, rx);
      u_host.frame_close;
      check({7'h0, dout_oe_n}, 8'h01);
      $display("test identity done");
   endtask
   task automatic t_busy;
      engine_busy <= 1'b1;
      repeat (2) @(posedge clk);
      status_read(8'h01);
      u_host.frame_open;
      u_host.shift(OP_IDENTITY, 8, rx);
      u_host.shift(8'h00, 8, rx);
      check({7'h0, u_host.saw_oe}, 8'h00);
      u_host.frame_close;
      u_host.frame_open;
      u_host.shift(OP_READ, 8, rx);
      repeat (4) u_host.shift(8'h00, 8, rx);
      check({7'h0, u_host.saw_oe}, 8'h00);
      u_host.frame_close;
      engine_busy <= 1'b0;
      repeat (2) @(posedge clk);
      status_read(8'h00);
      $display("test busy done");
   endtask
   task automatic rd(input logic [7:0] op, input logic [23:0] a, input int n);
      u_host.frame_open;
      u_host.shift(op, 8, rx);
      for (int i = 2; i >= 0; i--) u_host.shift(a[8*i+:8], 8, rx);
      if (op == OP_FAST_READ) u_host.shift(8'h00, 8, rx);
      for (int i = 0; i < n; i++) begin
         u_host.shift(8'h00, 8, rx);
         check(rx, pat(a[20:0] + 21'(i)));
      end
      u_host.shift(8'h00, 5, rx);
      u_host.frame_close;
      check({7'h0, dout_oe_n}, 8'h01);
   endtask
   task automatic t_read;
      rd(OP_READ, 24'hfffffe, 3);
      rd(OP_FAST_READ, 24'h000010, 2);
      status_read(8'h00);
      $display("test read done");
   endtask
   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      t_latch;
      t_ident;
      t_busy;
      t_read;
      test_done;
   end
   initial begin
      #8000000;
      fail_count++;
      test_done;
   end
endmodule

// *** dv/spi_host.sv ***
// behavioural spi host that frames commands and samples the reply
`timescale 1ns/1ps
module spi_host import sflash_pkg::*; (
   input wire logic clk,
   output spi_in_t spi_in,
   input wire logic dout,
   input wire logic dout_oe_n
);
   logic saw_oe = 1'b0;
   initial spi_in = '{sel_n: 1'b1, sclk: 1'b0, din: 1'b0};
   task automatic frame_open;
      saw_oe = 1'b0;
      spi_in.sel_n <= 1'b0;
      repeat (4) @(posedge clk);
   endtask
   // sclk idles low and stands still between frames
   // low phase 5 clk so the synchronised reply has landed
   task automatic shift(input logic [7:0] tx, input int n, output logic [7:0] rx);
      rx = 8'h00;
      for (int i = 7; i > 7 - n; i--) begin
         spi_in.din <= tx[i];
         repeat (5) @(posedge clk);
         rx[i] = dout_oe_n ? 1'b1 : dout;
         saw_oe = saw_oe | ~dout_oe_n;
         spi_in.sclk <= 1'b1;
         repeat (3) @(posedge clk);
         spi_in.sclk <= 1'b0;
      end
   endtask
   task automatic frame_close;
      repeat (2) @(posedge clk);
      spi_in.sel_n <= 1'b1;
      spi_in.din <= ~spi_in.din; // released line must not look held
      repeat (8) @(posedge clk);
   endtask
endmodule
